// >>> rtl/port_io_pkg.sv
// Constants and types for the parallel port and mode logic.
// Assumes one pclk domain and an APB master with 32-bit data.
`default_nettype none
package port_io_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_A_DATA = 8'h00;
    localparam logic [7:0] OFS_A_DIR = 8'h04;
    localparam logic [7:0] OFS_B_DATA = 8'h08;
    localparam logic [7:0] OFS_B_DIR = 8'h0C;
    localparam logic [7:0] OFS_C_DATA = 8'h10;
    localparam logic [7:0] OFS_C_DIR = 8'h14;
    localparam logic [7:0] OFS_E_DATA = 8'h18;
    localparam logic [7:0] OFS_F_DATA = 8'h1C;
    localparam logic [7:0] OFS_F_DIR = 8'h20;
    localparam logic [7:0] OFS_G_DATA = 8'h24;
    localparam logic [7:0] OFS_G_DIR = 8'h28;
    localparam logic [7:0] OFS_PULLUP = 8'h2C;
    localparam logic [7:0] OFS_OPTION_REG_TWO = 8'h30;
    localparam logic [7:0] OFS_MODE = 8'h34;
    // ==========================================================
    // Values after reset
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] OPTION_REG_TWO_RESET = 8'h00;
    localparam logic [2:0] PULLUP_RESET = 3'h0;
    // ==========================================================
    // Field positions
    localparam int STROBE_DIS_POS = 7;
    localparam int OPEN_DRAIN_POS = 5;
    localparam int PULLUP_B_POS = 0;
    localparam int PULLUP_F_POS = 1;
    localparam int PULLUP_G_POS = 2;
    // Synchroniser vector: A, B, C, E, F, G pin, two mode straps
    localparam int SYNC_W = 43;
    localparam int SY_A = 0;
    localparam int SY_B = 8;
    localparam int SY_C = 16;
    localparam int SY_E = 24;
    localparam int SY_F = 32;
    localparam int SY_G = 40;
    localparam int SY_MODE = 41;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_BOOT = 2'b00,
        MODE_TEST = 2'b01,
        MODE_SINGLE = 2'b10,
        MODE_EXPANDED = 2'b11
    } op_mode_t;
    typedef enum logic [1:0] {
        STROBE_IDLE = 2'b00,
        STROBE_LOW = 2'b01,
        STROBE_GAP = 2'b11
    } strobe_state_t;
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe_n;
    } port_drive_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic write;
        logic active;
    } ext_bus_t;
    // Port B, C, F and G pins act as general purpose lines only in these modes
    function automatic logic gpio_mode(input op_mode_t m);
        return (m == MODE_SINGLE) || (m == MODE_BOOT);
    endfunction
endpackage
`default_nettype wire

// >>> rtl/port_io_mode_mux.sv
// Parallel ports A, B, C, E, F, G, mode straps and instruction-start strobe.
// Assumes APB master on pclk; CPU bus and timer signals are on pclk too.
// How it works
// R01: Strobe pulls low in the opcode fetch cycle once the mode is known.
// R02: Strobe returns high for a cycle between back-to-back fetches.
// R03: A disable bit in option register two silences the strobe.
// R04: Mode straps are caught at reset release and pick one of four modes.
// R05: Read/write pin is port G bit 7 in single chip and bootstrap modes.
// R06: Read/write pin is high for reads, low for writes on the bus.
// R07: Ports B, C, F, G are general purpose only in single chip or bootstrap.
// R08: Port E is input only; its top two bits may serve the serial bus.
// R09: After reset inputs float and data latches show the reset state.
// R10: Port A reads pin levels; writes fill latches, driven only as outputs.
// R11: Port A writes do not disturb pins owned by a compare output.
// R12: Port A starts as inputs; direction rules once the timer lets go.
// R13: Port B is general purpose in single chip, high address in expanded.
// R14: Port B reads pin levels; latches drive only outputs in gpio modes.
// R15: Port B pull-ups switch through the pull-up assignment register.
// R16: Port C is general purpose in single chip, data bus in expanded.
// R17: Port C reads pins for inputs and latch level for outputs.
// R18: Port C starts as inputs in gpio modes, data bus otherwise.
// R19: Open-drain bit kills high drive: zero pulls low, one floats.
// R20: Open-drain option of port C applies in single chip mode only.
// R21: Direction bit set means output, clear means input; clear at reset.
`default_nettype none
module port_io_mode_mux
    import port_io_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mode straps
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    // CPU expanded bus
    input wire ext_bus_t cpu_bus,
    input wire logic cpu_opcode_fetch,
    output logic [7:0] ext_rdata,
    // Timer compare outputs on port A
    input wire logic [7:0] compare_out_en,
    input wire logic [7:0] compare_out_level,
    // Serial bus on port E top bits
    input wire logic serial_bus_en,
    input wire logic [1:0] serial_pull_low,
    // Pin levels
    input wire logic [7:0] pa_in,
    input wire logic [7:0] pb_in,
    input wire logic [7:0] pc_in,
    input wire logic [7:0] pe_in,
    input wire logic [7:0] pf_in,
    input wire logic single_bit_port_pin_in,
    // Pin drives
    output port_drive_t pa_drive,
    output port_drive_t pb_drive,
    output port_drive_t pc_drive,
    output port_drive_t pf_drive,
    output logic single_bit_port_pin_out,
    output logic single_bit_port_pin_oe_n,
    output logic [1:0] pe_top_level,
    output logic [1:0] pe_top_oe_n,
    output logic [2:0] pullup_enable,
    // Strobe and mode status
    output logic instr_start_strobe_n,
    output logic instr_start_oe_n,
    output op_mode_t op_mode,
    output logic mode_valid
);

    // ==========================================================
    // Pin synchronisers
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] pins;
    wire [SYNC_W-1:0] raw_pins = {mode_select_b, mode_select_a,
        single_bit_port_pin_in, pf_in, pe_in, pc_in, pb_in, pa_in};
    wire [SYNC_W-1:0] agree = ~(sync2 ^ sync3);

    // Not reset, so the straps are tracked while reset is held
    always_ff @(posedge pclk) begin
        sync1 <= raw_pins;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= '0;
        end else begin
            pins <= (sync3 & agree) | (pins & ~agree);
        end
    end

    wire [7:0] pa_pins = pins[SY_A +: 8];
    wire [7:0] pb_pins = pins[SY_B +: 8];
    wire [7:0] pc_pins = pins[SY_C +: 8];
    wire [7:0] pe_pins = pins[SY_E +: 8];
    wire [7:0] pf_pins = pins[SY_F +: 8];
    wire pg_pin = pins[SY_G];

    // ==========================================================
    // Mode capture at reset release
    wire straps_agree = &agree[SY_MODE +: 2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_valid <= 1'b0;
            op_mode <= MODE_BOOT;
        end else if (!mode_valid && straps_agree) begin
            mode_valid <= 1'b1; // R04
            op_mode <= op_mode_t'(sync3[SY_MODE +: 2]); // R04
        end
    end

    wire gpio = gpio_mode(op_mode); // R07
    wire single = (op_mode == MODE_SINGLE);
    wire bus_mode = mode_valid && !gpio;

    // ==========================================================
    // Register file
    logic [7:0] a_data;
    logic [7:0] a_dir;
    logic [7:0] b_data;
    logic [7:0] b_dir;
    logic [7:0] c_data;
    logic [7:0] c_dir;
    logic [7:0] f_data;
    logic [7:0] f_dir;
    logic g_data;
    logic g_dir;
    logic [2:0] pullup_sel;
    logic [7:0] option_reg_two;

    wire access = psel && penable;
    wire wr = access && pready && pwrite;
    wire strobe_dis = option_reg_two[STROBE_DIS_POS];
    wire open_drain = option_reg_two[OPEN_DRAIN_POS];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_data <= LATCH_RESET; // R09
            a_dir <= DIR_RESET; // R12 R21
            b_data <= LATCH_RESET;
            b_dir <= DIR_RESET;
            c_data <= LATCH_RESET;
            c_dir <= DIR_RESET;
            f_data <= LATCH_RESET;
            f_dir <= DIR_RESET;
            g_data <= 1'b0;
            g_dir <= 1'b0;
            pullup_sel <= PULLUP_RESET;
            option_reg_two <= OPTION_REG_TWO_RESET;
        end else if (wr) begin
            case (paddr)
                OFS_A_DATA: a_data <= pwdata[7:0]; // R10
                OFS_A_DIR: a_dir <= pwdata[7:0];
                OFS_B_DATA: b_data <= pwdata[7:0]; // R14
                OFS_B_DIR: b_dir <= pwdata[7:0];
                OFS_C_DATA: c_data <= pwdata[7:0]; // R17
                OFS_C_DIR: c_dir <= pwdata[7:0];
                OFS_F_DATA: f_data <= pwdata[7:0];
                OFS_F_DIR: f_dir <= pwdata[7:0];
                OFS_G_DATA: g_data <= pwdata[7];
                OFS_G_DIR: g_dir <= pwdata[7];
                OFS_PULLUP: pullup_sel <= pwdata[2:0]; // R15
                OFS_OPTION_REG_TWO: option_reg_two <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Read path
    wire [7:0] c_read = gpio ? ((c_dir & c_data) | (~c_dir & pc_pins)) : pc_pins; // R17
    wire g_read = g_dir ? g_data : pg_pin;
    logic [7:0] rd_byte;
    logic rd_hit;

    always_comb begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            OFS_A_DATA: rd_byte = pa_pins; // R10
            OFS_A_DIR: rd_byte = a_dir;
            OFS_B_DATA: rd_byte = pb_pins; // R14
            OFS_B_DIR: rd_byte = b_dir;
            OFS_C_DATA: rd_byte = c_read;
            OFS_C_DIR: rd_byte = c_dir;
            OFS_E_DATA: rd_byte = pe_pins; // R08
            OFS_F_DATA: rd_byte = pf_pins;
            OFS_F_DIR: rd_byte = f_dir;
            OFS_G_DATA: rd_byte = {g_read, 7'h00};
            OFS_G_DIR: rd_byte = {g_dir, 7'h00};
            OFS_PULLUP: rd_byte = {5'h00, pullup_sel};
            OFS_OPTION_REG_TWO: rd_byte = option_reg_two;
            OFS_MODE: rd_byte = {5'h00, mode_valid, op_mode};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access && !pready;
            pslverr <= access && !pready && !rd_hit;
            prdata <= (access && !pready && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // ==========================================================
    // Pin drive selection
    wire [7:0] next_pa_level = (compare_out_en & compare_out_level)
        | (~compare_out_en & a_data); // R11
    wire [7:0] next_pa_oe_n = ~(compare_out_en | a_dir); // R12 R21
    wire [7:0] next_pb_level = bus_mode ? cpu_bus.addr[15:8] : b_data; // R13
    wire [7:0] next_pb_oe_n = bus_mode ? 8'h00 : ~(b_dir & {8{mode_valid}}); // R14
    wire [7:0] next_pf_level = bus_mode ? cpu_bus.addr[7:0] : f_data; // R07
    wire [7:0] next_pf_oe_n = bus_mode ? 8'h00 : ~(f_dir & {8{mode_valid}});
    wire c_bus_drive = bus_mode && cpu_bus.active && cpu_bus.write; // R16 R18
    wire c_od = single && open_drain; // R20
    wire [7:0] c_gpio_drive = c_dir & {8{mode_valid}} & (c_od ? ~c_data : 8'hFF); // R19
    wire [7:0] next_pc_level = bus_mode ? cpu_bus.wdata : (c_od ? 8'h00 : c_data); // R19
    wire [7:0] next_pc_oe_n = bus_mode ? {8{!c_bus_drive}} : ~c_gpio_drive; // R18
    wire next_pg_level = bus_mode ? !(cpu_bus.active && cpu_bus.write) : g_data; // R06
    wire next_pg_oe_n = bus_mode ? 1'b0 : !(g_dir && mode_valid); // R05
    wire [1:0] next_pe_oe_n = ~({2{serial_bus_en}} & serial_pull_low); // R08

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_drive <= '{level: 8'h00, oe_n: 8'hFF}; // R09
            pb_drive <= '{level: 8'h00, oe_n: 8'hFF};
            pc_drive <= '{level: 8'h00, oe_n: 8'hFF};
            pf_drive <= '{level: 8'h00, oe_n: 8'hFF};
            single_bit_port_pin_out <= 1'b1;
            single_bit_port_pin_oe_n <= 1'b1;
            pe_top_level <= 2'h0;
            pe_top_oe_n <= 2'h3;
            pullup_enable <= PULLUP_RESET;
            ext_rdata <= 8'h00;
        end else begin
            pa_drive <= '{level: next_pa_level, oe_n: next_pa_oe_n};
            pb_drive <= '{level: next_pb_level, oe_n: next_pb_oe_n};
            pc_drive <= '{level: next_pc_level, oe_n: next_pc_oe_n};
            pf_drive <= '{level: next_pf_level, oe_n: next_pf_oe_n};
            single_bit_port_pin_out <= next_pg_level;
            single_bit_port_pin_oe_n <= next_pg_oe_n;
            pe_top_level <= 2'h0;
            pe_top_oe_n <= next_pe_oe_n;
            pullup_enable <= pullup_sel & {3{gpio}}; // R15
            ext_rdata <= pc_pins;
        end
    end

    // ==========================================================
    // Instruction-start strobe
    strobe_state_t strobe_state;
    strobe_state_t next_strobe_state;
    wire strobe_go = cpu_opcode_fetch && mode_valid && !strobe_dis; // R01 R03

    always_comb begin
        case (strobe_state)
            STROBE_IDLE: next_strobe_state = strobe_go ? STROBE_LOW : STROBE_IDLE;
            STROBE_LOW: next_strobe_state = STROBE_GAP; // R02
            STROBE_GAP: next_strobe_state = strobe_go ? STROBE_LOW : STROBE_IDLE;
            default: next_strobe_state = STROBE_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_state <= STROBE_IDLE;
            instr_start_strobe_n <= 1'b1;
            instr_start_oe_n <= 1'b1;
        end else begin
            strobe_state <= next_strobe_state;
            instr_start_strobe_n <= next_strobe_state != STROBE_LOW; // R01
            instr_start_oe_n <= next_strobe_state != STROBE_LOW; // R03
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    mode_hold_a: assert property (mode_valid && $past(mode_valid) |-> $stable(op_mode)) // R04
        else $error("mode changed after capture");
    strobe_start_a: assert property (strobe_go && strobe_state != STROBE_LOW // R01
        |=> !instr_start_strobe_n && !instr_start_oe_n)
        else $error("strobe missed an opcode fetch");
    strobe_gap_a: assert property (!instr_start_strobe_n |=> instr_start_strobe_n) // R02
        else $error("strobe stayed low across fetches");
    strobe_off_a: assert property (strobe_dis && strobe_state != STROBE_LOW // R03
        |=> instr_start_oe_n [*2])
        else $error("strobe driven while disabled");
    rw_level_a: assert property (bus_mode && cpu_bus.active // R06
        |=> !single_bit_port_pin_oe_n && single_bit_port_pin_out == !$past(cpu_bus.write))
        else $error("read/write pin level wrong");
    pg_input_a: assert property (mode_valid && gpio && !g_dir |=> single_bit_port_pin_oe_n) // R05
        else $error("port G driven as input");
    a_compare_a: assert property (compare_out_en[0] && wr && paddr == OFS_A_DATA // R11
        |=> pa_drive.level[0] == $past(compare_out_level[0]) && !pa_drive.oe_n[0])
        else $error("port A write disturbed compare pin");
    a_direction_a: assert property (compare_out_en == 8'h00 // R12
        |=> pa_drive.oe_n == ~$past(a_dir))
        else $error("port A direction ignored");
    b_addr_a: assert property (bus_mode // R13
        |=> pb_drive.oe_n == 8'h00 && pb_drive.level == $past(cpu_bus.addr[15:8]))
        else $error("port B not carrying high address");
    b_gpio_a: assert property (mode_valid && gpio // R14
        |=> pb_drive.oe_n == ~$past(b_dir) && pb_drive.level == $past(b_data))
        else $error("port B latch not on pins");
    c_bus_write_a: assert property (bus_mode && cpu_bus.active && cpu_bus.write // R16
        |=> pc_drive.oe_n == 8'h00 && pc_drive.level == $past(cpu_bus.wdata))
        else $error("port C not carrying write data");
    c_bus_float_a: assert property (bus_mode && !(cpu_bus.active && cpu_bus.write) // R18
        |=> pc_drive.oe_n == 8'hFF)
        else $error("port C driven outside a bus write");
    c_od_a: assert property (mode_valid && single && open_drain // R19
        |=> pc_drive.level == 8'h00 && (pc_drive.oe_n | ~$past(c_data)) == 8'hFF)
        else $error("port C open drain drove high");
    c_od_boot_a: assert property (mode_valid && op_mode == MODE_BOOT // R20
        |=> pc_drive.oe_n == ~$past(c_dir))
        else $error("open drain applied outside single chip");
    pullup_off_a: assert property (mode_valid && !gpio |=> pullup_enable == 3'h0) // R07
        else $error("pull-ups on in a bus mode");
    e_input_a: assert property (!serial_bus_en |=> pe_top_oe_n == 2'h3) // R08
        else $error("port E driven without serial bus");
    apb_ready_a: assert property (access && !pready |=> pready ##1 !pready) // R10
        else $error("APB answer not one cycle");

endmodule
`default_nettype wire

// >>> verification/port_pin_model.sv
// Board-side model of the port pins: resolves the A, B, C, F and G pin levels.
// Assumes the board holds a fixed level on each pin that the port leaves floating.
`default_nettype none
module port_pin_model
    import port_io_pkg::*;
(
    // Port drives
    input wire port_drive_t pa_drive,
    input wire port_drive_t pb_drive,
    input wire port_drive_t pc_drive,
    input wire port_drive_t pf_drive,
    input wire logic g_out,
    input wire logic g_oe_n,
    // Board levels, {F, C, B, A}
    input wire logic [31:0] board,
    input wire logic board_g,
    // Pin levels
    output logic [7:0] pa_in,
    output logic [7:0] pb_in,
    output logic [7:0] pc_in,
    output logic [7:0] pf_in,
    output logic g_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // A driven bit shows the port, a floating bit the board
    function automatic logic [7:0] pin(input port_drive_t d, input logic [7:0] b);
        return (d.level & ~d.oe_n) | (b & d.oe_n);
    endfunction
    assign pa_in = pin(pa_drive, board[7:0]);
    assign pb_in = pin(pb_drive, board[15:8]);
    assign pc_in = pin(pc_drive, board[23:16]);
    assign pf_in = pin(pf_drive, board[31:24]);
    assign g_in = g_oe_n ? board_g : g_out;
endmodule
`default_nettype wire

// >>> verification/port_io_mode_mux_tb_top.sv
// Testbench for the port and mode block: APB master, pin model, strobe stimulus.
// Assumes one pclk domain; board levels on floating pins are fixed.
`default_nettype none
module port_io_mode_mux_tb_top
    import port_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] BOARD = 32'h69C33C00;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic err;
    } row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic mode_a, mode_b, fetch, ser_en, g_out, g_oe_n, g_in;
    logic strobe_n, strobe_oe_n, mode_valid;
    logic [7:0] paddr, ext_rdata, cmp_en, cmp_lvl, pa_in, pb_in, pc_in, pf_in, pe_in;
    logic [31:0] pwdata, prdata, rdata;
    logic [1:0] ser_low, pe_lvl, pe_oe_n;
    logic [2:0] pu_en;
    ext_bus_t cpu_bus;
    port_drive_t pa_d, pb_d, pc_d, pf_d;
    op_mode_t op_mode;
    int n_mismatch, comparisons;
    row_t rows [18] = '{
        '{1'b1, OFS_A_DIR, 32'hFF, 1'b0}, '{1'b0, OFS_A_DIR, 32'hFF, 1'b0},
        '{1'b1, OFS_A_DATA, 32'h5A, 1'b0}, '{1'b0, OFS_A_DATA, 32'h5A, 1'b0},
        '{1'b1, OFS_B_DIR, 32'h0F, 1'b0}, '{1'b1, OFS_B_DATA, 32'hA5, 1'b0},
        '{1'b0, OFS_B_DATA, 32'h35, 1'b0}, '{1'b1, OFS_C_DIR, 32'hF0, 1'b0},
        '{1'b1, OFS_C_DATA, 32'h96, 1'b0}, '{1'b0, OFS_C_DATA, 32'h93, 1'b0},
        '{1'b1, OFS_PULLUP, 32'h07, 1'b0}, '{1'b0, OFS_PULLUP, 32'h07, 1'b0},
        '{1'b0, OFS_MODE, 32'h06, 1'b0}, '{1'b0, OFS_E_DATA, 32'h5E, 1'b0},
        '{1'b1, OFS_E_DATA, 32'hFF, 1'b0}, '{1'b0, OFS_E_DATA, 32'h5E, 1'b0},
        '{1'b0, 8'h38, 32'h00, 1'b1}, '{1'b1, 8'h3C, 32'h12, 1'b1}};
    // ==========================================================
    // Design, board and clock
    port_io_mode_mux i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_select_a(mode_a),
        .mode_select_b(mode_b), .cpu_bus(cpu_bus), .cpu_opcode_fetch(fetch),
        .ext_rdata(ext_rdata), .compare_out_en(cmp_en), .compare_out_level(cmp_lvl),
        .serial_bus_en(ser_en), .serial_pull_low(ser_low), .pa_in(pa_in),
        .pb_in(pb_in), .pc_in(pc_in), .pe_in(pe_in), .pf_in(pf_in),
        .single_bit_port_pin_in(g_in), .pa_drive(pa_d), .pb_drive(pb_d),
        .pc_drive(pc_d), .pf_drive(pf_d), .single_bit_port_pin_out(g_out),
        .single_bit_port_pin_oe_n(g_oe_n), .pe_top_level(pe_lvl),
        .pe_top_oe_n(pe_oe_n), .pullup_enable(pu_en),
        .instr_start_strobe_n(strobe_n), .instr_start_oe_n(strobe_oe_n),
        .op_mode(op_mode), .mode_valid(mode_valid));
    port_pin_model i_board (.pa_drive(pa_d), .pb_drive(pb_d), .pc_drive(pc_d),
        .pf_drive(pf_d), .g_out(g_out), .g_oe_n(g_oe_n), .board(BOARD),
        .board_g(1'b1), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in), .pf_in(pf_in),
        .g_in(g_in));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // ==========================================================
    // Shared tasks
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            check("pready", 32'h1, 32'h0);
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdata, err);
    endtask
    task automatic do_reset(input logic b, input logic a);
        presetn <= 1'b0;
        mode_b <= b;
        mode_a <= a;
        repeat (8) @(posedge pclk);
        check("reset oe_n", 32'hFFFFFFFF, {pa_d.oe_n, pb_d.oe_n, pc_d.oe_n, pf_d.oe_n});
        check("reset misc", 32'h6, {29'h0, g_oe_n, strobe_n, mode_valid});
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, OFS_MODE, 32'h0, rdata, err);
        check("mode", {30'h1, b, a}, rdata);
        apb(1'b0, OFS_A_DIR, 32'h0, rdata, err);
        check("a dir reset", 32'h0, rdata);
    endtask
    task automatic strobe_run(input logic [7:0] pat, input logic en);
        logic exp;
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            exp = !(en && i >= 2 && pat[(i + 6) % 8]);
            check("strobe", {30'h0, exp, exp}, {30'h0, strobe_n, strobe_oe_n});
            fetch <= (i < 8) ? pat[i] : 1'b0;
        end
    endtask
    task automatic bus_run();
        wr(OFS_OPTION_REG_TWO, 32'h20);
        cpu_bus <= '{16'h12C4, 8'h3D, 1'b1, 1'b1};
        wr(OFS_B_DIR, 32'hFF);
        wr(OFS_B_DATA, 32'h00);
        wr(OFS_PULLUP, 32'h07);
        repeat (2) @(posedge pclk);
        check("bus wr", 32'h12C43D00, {pb_d.level, pf_d.level, pc_d.level, pb_d.oe_n});
        check("bus oe", 32'h0, {pf_d.oe_n, pc_d.oe_n, 13'h0, pu_en[0], g_out, g_oe_n});
        cpu_bus <= '{16'h12C4, 8'h3D, 1'b0, 1'b1};
        repeat (8) @(posedge pclk);
        check("bus read", 32'h0000FF02, {16'h0, pc_d.oe_n, 6'h0, g_out, g_oe_n});
        check("ext rdata", 32'hC3, {24'h0, ext_rdata});
        cpu_bus <= '0;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, fetch, ser_en} = '0;
        {mode_b, mode_a} = 2'b10;
        paddr = 8'h00;
        pwdata = 32'h0;
        cpu_bus = '0;
        {cmp_en, cmp_lvl} = '0;
        ser_low = 2'b01;
        pe_in = 8'h5E;
        do_reset(1'b1, 1'b0);
        for (int i = 0; i < 18; i++) begin
            if (!rows[i].wr) repeat (6) @(posedge pclk);
            apb(rows[i].wr, rows[i].a, rows[i].d, rdata, err);
            if (!rows[i].wr) check("row rdata", rows[i].d, rdata);
            check("row err", {31'h0, rows[i].err}, {31'h0, err});
        end
        check("pins single", 32'h07F0, {21'h0, pu_en, pb_d.oe_n});
        strobe_run(8'b0001_0101, 1'b1);
        wr(OFS_OPTION_REG_TWO, 32'h80);
        strobe_run(8'b0000_0101, 1'b0);
        cmp_en <= 8'h0F;
        cmp_lvl <= 8'h03;
        wr(OFS_A_DATA, 32'hF0);
        repeat (2) @(posedge pclk);
        check("pa compare", 32'hF3, {24'h0, pa_d.level});
        cmp_en <= 8'h00;
        repeat (2) @(posedge pclk);
        check("pa released", 32'hF0, {24'h0, pa_d.level});
        ser_en <= 1'b1;
        wr(OFS_C_DIR, 32'hFF);
        wr(OFS_OPTION_REG_TWO, 32'h20);
        wr(OFS_C_DATA, 32'h0F);
        repeat (2) @(posedge pclk);
        check("pc open drain", 32'h0F00, {16'h0, pc_d.oe_n, pc_d.level & ~pc_d.oe_n});
        check("pe top", 32'h2, {28'h0, pe_lvl, pe_oe_n});
        do_reset(1'b0, 1'b0);
        wr(OFS_G_DIR, 32'h80);
        wr(OFS_G_DATA, 32'h80);
        wr(OFS_C_DIR, 32'hFF);
        wr(OFS_OPTION_REG_TWO, 32'h20);
        wr(OFS_C_DATA, 32'h0F);
        repeat (2) @(posedge pclk);
        check("boot pins", 32'h0000003E, {14'h0, pc_d.oe_n, pc_d.level, g_out, g_oe_n});
        do_reset(1'b0, 1'b1);
        bus_run();
        do_reset(1'b1, 1'b1);
        bus_run();
        complete_run();
    end
endmodule
`default_nettype wire
